/* core/qbpl_pkg.sv */
package qbpl_pkg;
	// ----------------------------------------
	// Machine cycle timing
	// ----------------------------------------
	localparam int STATES_PER_CYCLE = 6;
	localparam int PHASES_PER_STATE = 2;
	localparam logic [3:0] SLOT_LAST = 4'hB;
	localparam logic [3:0] SLOT_STATE1_PHASE1 = 4'h0;
	localparam logic [3:0] SLOT_S5P1 = 4'h8;
	localparam logic [3:0] SLOT_S5P2 = 4'h9;
	localparam logic [3:0] SLOT_STATE6_PHASE2 = 4'hB;
	// ----------------------------------------
	// Ports and values
	// ----------------------------------------
	localparam int NUM_PORTS = 4;
	localparam logic [7:0] LATCH_RESET = 8'hFF;
	localparam logic [1:0] PORT_ZERO = 2'h0;
	localparam logic [1:0] PORT_ONE = 2'h1;
	localparam logic [1:0] PORT_THREE = 2'h3;
	localparam int BIT_T2_COUNT = 0;
	localparam int BIT_T2_TRIG = 1;
	localparam int BIT_RXD = 0;
	localparam int BIT_TXD = 1;
	localparam int BIT_IRQ0 = 2;
	localparam int BIT_IRQ1 = 3;
	localparam int BIT_T0_COUNT = 4;
	localparam int BIT_T1_COUNT = 5;
	localparam int BIT_WR = 6;
	localparam int BIT_RD = 7;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_READ = 4'h1,
		OP_WRITE = 4'h2,
		OP_ANL = 4'h3,
		OP_ORL = 4'h4,
		OP_XRL = 4'h5,
		OP_INC = 4'h6,
		OP_DEC = 4'h7,
		OP_DJNZ = 4'h8,
		OP_JBC = 4'h9,
		OP_CPL = 4'hA,
		OP_MOVC = 4'hB,
		OP_CLR = 4'hC,
		OP_SETB = 4'hD
	} qbpl_op_t;

	typedef struct packed {
		qbpl_op_t op;
		logic [1:0] port;
		logic [2:0] bit_sel;
		logic [7:0] data;
	} qbpl_req_t;

	typedef struct packed {
		logic timer2_count_input;
		logic timer2_trigger_input;
		logic serial_rx;
		logic ext_irq_zero_input;
		logic ext_irq_one_input;
		logic timer_zero_count_input;
		logic timer_one_count_input;
	} qbpl_alt_in_t;

	typedef struct packed {
		logic serial_rx_out;
		logic serial_tx_out;
		logic wr_strobe_n;
		logic rd_strobe_n;
	} qbpl_alt_out_t;
endpackage

/* core/qbpl_timing.sv */
`timescale 1ns/1ps
module qbpl_timing (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Slot position
	output logic [3:0] o_slot
);
	import qbpl_pkg::*;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_slot <= SLOT_LAST;
		end else if (o_slot == SLOT_LAST) begin
			o_slot <= SLOT_STATE1_PHASE1;
		end else begin
			o_slot <= o_slot + 4'h1;
		end
	end
endmodule

/* core/qbpl_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Written latch value loads at state6_phase2
// RULE2 - Output buffer captures latch only in phase1
// RULE3 - New value reaches pin at state1_phase1
// RULE4 - Pin reads sample pin in state 5
// RULE5 - Edge means sample differs from previous cycle; the code flags only high-to-low changes
// RULE6 - Source holds each level one machine cycle
// RULE7 - Read-modify-write takes operand from latch
// RULE8 - Other port reads return pin levels
// RULE9 - Listed logic, jump and bit ops read latch
// RULE10 - Bit writes rewrite whole byte, one bit changed
// RULE11 - Instruction kind alone selects latch or pin
// RULE12 - Port one bits 0,1 feed timer 2
// RULE13 - Port three bits 0,1 carry serial lines
// RULE14 - Port three bits 2..5 interrupts, timer inputs
// RULE15 - Port three bits 6,7 memory write/read strobes
// RULE16 - Reset sets every latch bit to one
// RULE17 - Alternate-function pins need latch at one
// RULE18 - Four 8-bit latches, byte and bit writable
module qbpl_top (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Core request, one per machine cycle at its last slot
	input wire logic I_REQ_VALID,
	input wire qbpl_pkg::qbpl_req_t I_REQ,
	// Alternate outputs from peripherals
	input wire qbpl_pkg::qbpl_alt_out_t I_ALT_OUT,
	// Pins
	input wire logic [31:0] I_PIN,
	output logic [31:0] O_PIN,
	output logic [31:0] O_PIN_OE_N,
	// Results to core
	output logic [7:0] O_RD_DATA,
	output logic O_RD_VALID,
	output logic [7:0] O_RMW_OPERAND,
	// Sampled alternate inputs and edges, slot position
	output qbpl_pkg::qbpl_alt_in_t O_ALT_IN,
	output qbpl_pkg::qbpl_alt_in_t O_ALT_FALL,
	output logic [3:0] O_SLOT
);
	import qbpl_pkg::*;

	logic [3:0] slot;
	logic [7:0] latch [NUM_PORTS];
	logic [31:0] pin_meta;
	logic [31:0] pin_sync;
	logic [31:0] sample;
	logic [7:0] next_byte;
	logic [7:0] operand;
	logic req_held_valid;
	qbpl_req_t req_held;
	qbpl_alt_in_t alt_now;

	function automatic logic is_rmw(input qbpl_op_t op);
		return (op >= OP_ANL);
	endfunction

	function automatic logic is_bitop(input qbpl_op_t op);
		return (op >= OP_JBC);
	endfunction

	qbpl_timing u_timing (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.o_slot(slot)
	);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin_meta <= 32'hFFFFFFFF;
			pin_sync <= 32'hFFFFFFFF;
		end else begin
			pin_meta <= I_PIN;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			req_held_valid <= 1'b0;
			req_held <= '0;
		end else if (slot == SLOT_LAST) begin
			req_held_valid <= I_REQ_VALID;
			req_held <= I_REQ;
		end
	end

	// ----------------------------------------
	// Pin sampling, once per machine cycle
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sample <= 32'hFFFFFFFF;
		end else if (slot == SLOT_S5P2) begin
			sample <= pin_sync; // RULE4
		end
	end

	// Operand source chosen by instruction kind only
	always_comb begin
		operand = latch[req_held.port]; // RULE7 RULE11
		if (!is_rmw(req_held.op)) begin
			operand = pin_sync[req_held.port*8 +: 8]; // RULE8
		end
	end

	always_comb begin
		next_byte = operand;
		unique case (req_held.op)
			OP_WRITE: next_byte = req_held.data;
			OP_ANL: next_byte = operand & req_held.data; // RULE9
			OP_ORL: next_byte = operand | req_held.data;
			OP_XRL: next_byte = operand ^ req_held.data;
			OP_INC: next_byte = operand + 8'h01;
			OP_DEC: next_byte = operand - 8'h01;
			OP_DJNZ: next_byte = operand - 8'h01;
			OP_JBC: next_byte[req_held.bit_sel] = 1'b0; // RULE10
			OP_CPL: next_byte[req_held.bit_sel] = ~operand[req_held.bit_sel];
			OP_MOVC: next_byte[req_held.bit_sel] = req_held.data[0];
			OP_CLR: next_byte[req_held.bit_sel] = 1'b0;
			OP_SETB: next_byte[req_held.bit_sel] = 1'b1;
			default: next_byte = operand;
		endcase
	end

	// ----------------------------------------
	// Read results at state 5
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RD_DATA <= 8'h00;
			O_RD_VALID <= 1'b0;
			O_RMW_OPERAND <= 8'h00;
		end else begin
			O_RD_VALID <= 1'b0;
			if (slot == SLOT_S5P1 && req_held_valid && req_held.op != OP_NONE) begin
				O_RD_DATA <= operand; // RULE4 RULE8
				O_RD_VALID <= 1'b1;
				O_RMW_OPERAND <= latch[req_held.port];
			end
		end
	end

	// ----------------------------------------
	// Latches
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				latch[p] <= LATCH_RESET; // RULE16
			end
		end else if (slot == SLOT_STATE6_PHASE2 && req_held_valid &&
				(req_held.op == OP_WRITE || is_rmw(req_held.op))) begin
			latch[req_held.port] <= next_byte; // RULE1 RULE18
		end
	end

	// ----------------------------------------
	// Output buffer, captures in phase 1 only
	// ----------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PIN <= 32'hFFFFFFFF;
			O_PIN_OE_N <= 32'hFFFFFFFF;
		end else if (slot[0] == 1'b0) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int b = 0; b < 8; b++) begin
					O_PIN[p*8+b] <= 1'b0;
					O_PIN_OE_N[p*8+b] <= latch[p][b]; // RULE2 RULE3
				end
			end
			// Alternate outputs pull low whatever the latch bit holds
			if (!I_ALT_OUT.serial_rx_out) O_PIN_OE_N[24+BIT_RXD] <= 1'b0; // RULE13 RULE17
			if (!I_ALT_OUT.serial_tx_out) O_PIN_OE_N[24+BIT_TXD] <= 1'b0; // RULE13
			if (!I_ALT_OUT.wr_strobe_n) O_PIN_OE_N[24+BIT_WR] <= 1'b0; // RULE15
			if (!I_ALT_OUT.rd_strobe_n) O_PIN_OE_N[24+BIT_RD] <= 1'b0; // RULE15
		end
	end

	// ----------------------------------------
	// Alternate inputs and edge detection
	// ----------------------------------------
	always_comb begin
		alt_now.timer2_count_input = sample[8+BIT_T2_COUNT]; // RULE12
		alt_now.timer2_trigger_input = sample[8+BIT_T2_TRIG];
		alt_now.serial_rx = sample[24+BIT_RXD]; // RULE13
		alt_now.ext_irq_zero_input = sample[24+BIT_IRQ0]; // RULE14
		alt_now.ext_irq_one_input = sample[24+BIT_IRQ1];
		alt_now.timer_zero_count_input = sample[24+BIT_T0_COUNT];
		alt_now.timer_one_count_input = sample[24+BIT_T1_COUNT];
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ALT_IN <= '1;
			O_ALT_FALL <= '0;
		end else if (slot == SLOT_STATE6_PHASE2) begin
			O_ALT_IN <= alt_now;
			O_ALT_FALL <= O_ALT_IN & ~alt_now; // RULE5 RULE6
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_SLOT <= SLOT_LAST;
		end else begin
			O_SLOT <= slot;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_LATCH_ONLY_STATE6_PHASE2: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE1
		(latch[0] != $past(latch[0])) |-> ($past(slot) == SLOT_STATE6_PHASE2))
		else $error("latch changed outside state6_phase2");
	AST_PIN_PHASE1: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE2
		(O_PIN_OE_N != $past(O_PIN_OE_N)) |-> ($past(slot[0]) == 1'b0))
		else $error("pin changed outside phase1");
	AST_PIN_FOLLOWS: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE3
		(slot == SLOT_STATE1_PHASE1 && latch[1] != $past(latch[1])) |->
		(O_PIN_OE_N[15:8] == $past(latch[1])) ##1 (O_PIN_OE_N[15:8] == latch[1]))
		else $error("pin did not follow latch at state1_phase1");
	AST_RD_AT_S5: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE4
		O_RD_VALID |-> ($past(slot) == SLOT_S5P1))
		else $error("read not in state 5");
	AST_FALL_EDGE: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE5
		(slot == SLOT_STATE1_PHASE1) |-> (O_ALT_FALL.timer_zero_count_input ==
		($past(O_ALT_IN.timer_zero_count_input) && !O_ALT_IN.timer_zero_count_input)))
		else $error("fall without low sample");
	AST_RMW_LATCH: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE7
		(O_RD_VALID && is_rmw(req_held.op)) |-> (O_RD_DATA == O_RMW_OPERAND))
		else $error("rmw did not read latch");
	AST_SETB_BIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE10
		(slot == SLOT_STATE6_PHASE2 && req_held_valid && req_held.op == OP_SETB) |=>
		(latch[$past(req_held.port)][$past(req_held.bit_sel)] == 1'b1))
		else $error("setb did not set bit");
	AST_SLOT_WRAP: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // slot wraps from last slot to first
		(slot == SLOT_LAST) |=> (slot == SLOT_STATE1_PHASE1))
		else $error("cycle not twelve slots");
	COV_WRITE: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
		slot == SLOT_STATE6_PHASE2 && req_held_valid && req_held.op == OP_WRITE);
	COV_RMW: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_RD_VALID && is_rmw(req_held.op));
	COV_BIT: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_RD_VALID && is_bitop(req_held.op));
	COV_FALL: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_ALT_FALL.timer2_count_input);
endmodule

/* sim/qbpl_pins.sv */
`timescale 1ns/1ps
module qbpl_pins (
	// Clock, reset, slot
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_slot,
	// Source levels and device pull-downs
	input wire logic [31:0] i_ext,
	input wire logic [31:0] i_oe_n,
	// Resolved pin levels
	output logic [31:0] o_pin
);
	logic [31:0] ext_held;
	// Source levels move once per machine cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_held <= 32'hFFFFFFFF;
		end else if (i_slot == 4'hA) begin
			ext_held <= i_ext;
		end
	end
	// Pull-up unless either side pulls low
	assign o_pin = ext_held & i_oe_n;
endmodule

/* sim/test_qbpl_top.sv */
`timescale 1ns/1ps
module test_qbpl_top;
	import qbpl_pkg::*;
	logic I_CLK, I_RST_N, I_REQ_VALID, O_RD_VALID, v;
	qbpl_req_t I_REQ, r;
	qbpl_alt_out_t I_ALT_OUT;
	qbpl_alt_in_t O_ALT_IN, O_ALT_FALL;
	logic [31:0] I_PIN, O_PIN, O_PIN_OE_N, ext, oe_old, pins;
	logic [7:0] O_RD_DATA, O_RMW_OPERAND;
	logic [3:0] O_SLOT;
	logic [7:0] lat [4];
	logic [6:0] prev_alt, cur_alt;
	int fails, comparisons, seed;
	qbpl_top DUT (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ),
		.I_ALT_OUT(I_ALT_OUT), .I_PIN(I_PIN), .O_PIN(O_PIN), .O_PIN_OE_N(O_PIN_OE_N),
		.O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID), .O_RMW_OPERAND(O_RMW_OPERAND),
		.O_ALT_IN(O_ALT_IN), .O_ALT_FALL(O_ALT_FALL), .O_SLOT(O_SLOT));
	qbpl_pins far_side (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_slot(O_SLOT), .i_ext(ext),
		.i_oe_n(O_PIN_OE_N), .o_pin(I_PIN));
	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic [7:0] apply(qbpl_op_t op, logic [7:0] l, logic [2:0] b,
		logic [7:0] d);
		logic [7:0] n;
		n = l;
		case (op)
			OP_WRITE: n = d;
			OP_ANL: n = l & d;
			OP_ORL: n = l | d;
			OP_XRL: n = l ^ d;
			OP_INC: n = l + 8'h01;
			OP_DEC, OP_DJNZ: n = l - 8'h01;
			OP_JBC, OP_CLR: n[b] = 1'b0;
			OP_CPL: n[b] = ~l[b];
			OP_MOVC: n[b] = d[0];
			OP_SETB: n[b] = 1'b1;
			default: n = l;
		endcase
		return n;
	endfunction
	function automatic logic [31:0] oe_model(logic [3:0] a);
		return {lat[3] & {a[0], a[1], 4'hF, a[2], a[3]}, lat[2], lat[1], lat[0]};
	endfunction
	function automatic logic [6:0] alt_map(logic [31:0] p);
		return {p[8], p[9], p[24], p[26], p[27], p[28], p[29]};
	endfunction
	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t byte got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t word got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("Mismatches %0d, comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One request, then results through the next slot 0
	task automatic mcycle();
		logic [7:0] nl;
		int k;
		k = 0;
		do begin
			@(posedge I_CLK);
			#1;
			k++;
		end while (O_SLOT !== 4'h9 && k < 40);
		if (k >= 40) begin
			fails++;
			$display("[ERR] %0t slot counter stuck", $time);
			close_out();
		end
		@(posedge I_CLK);
		I_REQ_VALID <= v;
		I_REQ <= r;
		I_ALT_OUT <= 4'($random(seed));
		ext <= $random(seed) | $random(seed);
		@(posedge I_CLK);
		I_REQ_VALID <= 1'b0;
		repeat (9) @(posedge I_CLK);
		#1;
		oe_old = oe_model(I_ALT_OUT);
		pins = ext & oe_old;
		cur_alt = alt_map(pins);
		nl = v ? apply(r.op, lat[r.port], r.bit_sel, r.data) : lat[r.port];
		cmp_byte({7'h00, O_RD_VALID}, {7'h00, v && r.op != OP_NONE});
		if (v && r.op == OP_READ) begin
			cmp_byte({7'h00, O_RD_VALID}, 8'h01);
			cmp_byte(O_RD_DATA, pins[r.port*8 +: 8]);
		end
		if (v && r.op >= OP_ANL) cmp_byte(O_RMW_OPERAND, lat[r.port]);
		repeat (3) @(posedge I_CLK);
		#1;
		cmp_word(O_PIN_OE_N, oe_old);
		cmp_byte({1'b0, O_ALT_IN}, {1'b0, cur_alt});
		cmp_byte({1'b0, O_ALT_FALL}, {1'b0, prev_alt & ~cur_alt});
		lat[r.port] = nl;
		@(posedge I_CLK);
		#1;
		oe_old = oe_model(I_ALT_OUT);
		cmp_word(O_PIN_OE_N, oe_old);
		cmp_word(O_PIN, 32'h00000000);
		prev_alt = alt_map(ext & oe_old);
	endtask
	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		I_CLK = 1'b0;
		forever #20 I_CLK = ~I_CLK;
	end
	initial begin
		I_RST_N = 1'b0;
		I_REQ_VALID = 1'b0;
		I_REQ = '0;
		I_ALT_OUT = 4'hF;
		ext = 32'hFFFFFFFF;
		fails = 0;
		comparisons = 0;
		seed = 32'h6f684fd0;
		prev_alt = 7'h7F;
		for (int p = 0; p < NUM_PORTS; p++) lat[p] = LATCH_RESET;
		repeat (10) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		#1;
		cmp_word(O_PIN_OE_N, 32'hFFFFFFFF);
		cmp_byte({1'b0, O_ALT_IN}, 8'h7F);
		for (int i = 0; i < 90; i++) begin
			r.op = qbpl_op_t'(4'((i < 14) ? i : $unsigned($random(seed)) % 14));
			r.port = 2'($random(seed));
			r.bit_sel = 3'($random(seed));
			r.data = 8'($random(seed));
			v = (i % 9) != 8;
			mcycle();
		end
		close_out();
	end
endmodule
